//--- rtl/sbchc_pkg.sv
// Shared constants, encodings and carrier types of the host control interface
package sbchc_pkg;

    // ==========================================================
    // Timing
    localparam int SYS_CLK_PERIOD_NS = 10;
    localparam int MS_IN_NS = 1000000;
    localparam int CYCLES_PER_MS = MS_IN_NS / SYS_CLK_PERIOD_NS;
    localparam logic [15:0] RESET_TIME_MS = 16'h0001;
    localparam logic [15:0] NREQ_TIMEOUT_MS = 16'h0096;
    localparam logic [15:0] WD_DEFAULT_MS = 16'h0096;
    localparam logic [15:0] CYCLIC_BASE_MS = 16'h000A;
    localparam int RST_FILTER_NS = 100;
    localparam logic [7:0] RST_FILTER_CYCLES = 8'((RST_FILTER_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);
    localparam int SENSE_SETTLE_NS = 1000;
    localparam logic [7:0] SENSE_SETTLE_CYCLES = 8'((SENSE_SETTLE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);

    // ==========================================================
    // Serial frame
    localparam logic [3:0] FRAME_BITS = 4'h8;
    localparam logic [3:0] BIT_COUNT_MAX = 4'h9;
    localparam logic [2:0] ADDR_MODE = 3'h0;
    localparam logic [2:0] ADDR_SWITCH = 3'h1;
    localparam logic [2:0] ADDR_MUX = 3'h2;
    localparam logic [2:0] ADDR_SUPPLY = 3'h3;
    localparam logic [2:0] ADDR_CYCLIC = 3'h4;
    localparam logic [2:0] ADDR_STATUS = 3'h5;

    // ==========================================================
    // Field layouts and reset values
    localparam logic [1:0] MODE_CMD_NORMAL = 2'h0;
    localparam logic [1:0] MODE_CMD_STOP = 2'h1;
    localparam logic [1:0] MODE_CMD_SLEEP = 2'h2;
    localparam int SW_ONE_ON_BIT = 0;
    localparam int SW_TWO_ON_BIT = 1;
    localparam int SW_ONE_PULSE_BIT = 2;
    localparam int SW_TWO_PULSE_BIT = 3;
    localparam int SUPPLY_ON_BIT = 0;
    localparam int CYC_EN_BIT = 0;
    localparam int CYC_SEL_BIT = 1;
    localparam int CYC_PER_LSB = 2;
    localparam logic [2:0] MUX_SEL_NONE = 3'h0;
    localparam logic [2:0] MUX_SEL_WAKE = 3'h1;
    localparam logic [2:0] MUX_SEL_TEMP = 3'h2;
    localparam logic [2:0] MUX_SEL_SENSE = 3'h3;
    localparam logic [1:0] STRAP_GROUND = 2'h0;
    localparam logic [1:0] STRAP_OPEN = 2'h1;
    localparam logic [1:0] STRAP_RESISTOR = 2'h2;
    localparam logic [23:0] SYNC_RESET = 24'h000016;

    typedef enum logic [2:0] {
        MODE_RESET = 3'b000,
        MODE_NREQ = 3'b001,
        MODE_NORMAL = 3'b010,
        MODE_STOP = 3'b011,
        MODE_SLEEP = 3'b100
    } sbchc_mode_t;

    typedef struct packed {
        logic write;
        logic [2:0] addr;
        logic [3:0] data;
    } sbchc_frame_t;

    typedef struct packed {
        logic wake_level;
        logic wake_flag;
        logic fault_flag;
        logic pulse_enabled;
        logic spare;
        logic [2:0] mode;
    } sbchc_status_t;

endpackage

//--- rtl/sbchc_core.sv
// Host control interface of the system basis chip: serial port, modes, wake, switches
// ==========================================================
// Notes on behaviour
// - Chip select rising edge ends the transfer and latches shifted data.
// - Only frames of exactly eight clocked bits are valid.
// - Chip select rising edge wakes the device out of Stop.
// - Analog multiplexer source selected over serial; wake input or temperature among them.
// - Pulse input drives switches only in Normal Request or Normal.
// - Pulse input ignored for switches until switch control register is written.
// - Device drives reset line low on reset; host may pull it low.
// - Release of the reset line high enters Normal Request, or Normal when the strap tied to ground disables the watchdog.
// - Reset line input is filtered against short glitches.
// - Interrupt line reports events in active modes and wake from Stop.
// - In active modes and Stop, with the reset line high, interrupt line stays low until the status read acknowledges it.
// - Strap tied to ground disables the watchdog.
// - Strap left open uses the internal 150 ms watchdog period.
// - Strap with resistor sets the window watchdog period.
// - Wake input readable as a level and used for low-power wake.
// - Cyclic sense powers a switch, samples wake input, wakes on difference.
// - Without cyclic sense any change of an unmuxed wake input wakes from Stop or Sleep.
// - Wake input routed to multiplexer loses digital and wake function.
// - Both switches serial controlled, pulse driven, and usable for cyclic sense.
// - Sensor supply switched over serial while in Normal mode.
// - Watchdog overflow resets the microcontroller through the reset line.
// - Input sampled on rising serial clock, output changed on falling edge.
// - Serial output is high impedance while chip select is high.
// - Stop wake goes to Normal Request with interrupt, except chip select or reset.
module sbchc_core #(
    parameter int CYCLES_PER_MS_P = sbchc_pkg::CYCLES_PER_MS
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe_n,
    input wire logic reset_line_in,
    output logic reset_line_out,
    output logic reset_line_oe_n,
    output logic irq_n,
    input wire logic switch_pulse_input,
    input wire logic [1:0] watchdog_strap_pin,
    input wire logic [15:0] watchdog_resistor_ms,
    input wire logic multipurpose_wake_input,
    input wire logic lin_wake_event,
    input wire logic fault_event,
    output logic high_side_switch_one,
    output logic high_side_switch_two,
    output logic sensor_supply_output,
    output logic [2:0] analog_mux_output,
    output sbchc_pkg::sbchc_mode_t device_mode
);
    import sbchc_pkg::*;

    localparam int PW = $clog2(CYCLES_PER_MS_P);
    localparam logic [PW-1:0] PRE_LAST = PW'(CYCLES_PER_MS_P - 1);

    function automatic logic is_active(input sbchc_mode_t m);
        is_active = (m == MODE_NREQ) || (m == MODE_NORMAL);
    endfunction

    function automatic logic is_low_power(input sbchc_mode_t m);
        is_low_power = (m == MODE_STOP) || (m == MODE_SLEEP);
    endfunction

    // ==========================================================
    // Pin synchronisers
    logic [23:0] sync1_reg;
    logic [23:0] sync2_reg;
    logic sclk_d_reg;
    logic cs_d_reg;
    logic wake_d_reg;
    wire [23:0] pins_async = {watchdog_resistor_ms, watchdog_strap_pin, spi_sclk, spi_cs_n, spi_mosi,
                              reset_line_in, switch_pulse_input, multipurpose_wake_input};
    wire [15:0] res_ms_s = sync2_reg[23:8];
    wire [1:0] strap_s = sync2_reg[7:6];
    wire sclk_s = sync2_reg[5];
    wire cs_s = sync2_reg[4];
    wire mosi_s = sync2_reg[3];
    wire rst_s = sync2_reg[2];
    wire pulse_s = sync2_reg[1];
    wire wake_s = sync2_reg[0];

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            sync1_reg <= SYNC_RESET;
            sync2_reg <= SYNC_RESET;
            sclk_d_reg <= 1'b0;
            cs_d_reg <= 1'b1;
            wake_d_reg <= 1'b0;
        end else begin
            sync1_reg <= pins_async;
            sync2_reg <= sync1_reg;
            sclk_d_reg <= sclk_s;
            cs_d_reg <= cs_s;
            wake_d_reg <= wake_s;
        end
    end

    // ==========================================================
    // Serial frame
    sbchc_mode_t mode_reg;
    sbchc_mode_t mode_next;
    logic [7:0] shift_in_reg;
    logic [7:0] shift_out_reg;
    logic [3:0] bit_cnt_reg;
    logic miso_reg;
    logic miso_oe_n_reg;
    logic [1:0] snap_reg;
    logic wake_flag_reg;
    logic fault_flag_reg;
    logic pulse_en_reg;
    logic [2:0] mux_sel_reg;

    wire cs_rise = cs_s & ~cs_d_reg;
    wire cs_fall = ~cs_s & cs_d_reg;
    wire sclk_rise = sclk_s & ~sclk_d_reg & ~cs_s;
    wire sclk_fall = ~sclk_s & sclk_d_reg & ~cs_s;
    wire frame_ok = cs_rise & (bit_cnt_reg == FRAME_BITS);
    sbchc_frame_t frame;
    assign frame = sbchc_frame_t'(shift_in_reg);
    wire wr_ok = frame_ok & frame.write & is_active(mode_reg);
    wire wr_mode = wr_ok & (frame.addr == ADDR_MODE);
    wire wr_switch = wr_ok & (frame.addr == ADDR_SWITCH);
    wire rd_status = frame_ok & ~frame.write & (frame.addr == ADDR_STATUS);
    wire wake_muxed = (mux_sel_reg == MUX_SEL_WAKE);
    wire wake_level = wake_s & ~wake_muxed;
    sbchc_status_t status;
    assign status = '{wake_level, wake_flag_reg, fault_flag_reg, pulse_en_reg, 1'b0, mode_reg};

    // Edges come from the synchronised clock, so the link must run well below sys_clk / 4
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            shift_in_reg <= 8'h00;
            bit_cnt_reg <= 4'h0;
        end else if (cs_fall) begin
            shift_in_reg <= 8'h00;
            bit_cnt_reg <= 4'h0;
        end else if (sclk_rise) begin
            shift_in_reg <= {shift_in_reg[6:0], mosi_s};
            bit_cnt_reg <= (bit_cnt_reg == BIT_COUNT_MAX) ? bit_cnt_reg : bit_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            shift_out_reg <= 8'h00;
            miso_reg <= 1'b0;
            miso_oe_n_reg <= 1'b1;
            snap_reg <= 2'h0;
        end else begin
            miso_oe_n_reg <= cs_s;
            if (cs_fall) begin
                shift_out_reg <= status;
                miso_reg <= status.wake_level;
                snap_reg <= {status.wake_flag, status.fault_flag};
            end else if (sclk_fall) begin
                shift_out_reg <= {shift_out_reg[6:0], 1'b0};
                miso_reg <= shift_out_reg[6];
            end
        end
    end

    // ==========================================================
    // Control fields
    logic [3:0] sw_ctrl_reg;
    logic supply_on_reg;
    logic [3:0] cyc_cfg_reg;

    always_ff @(posedge sys_clk) begin
        if (!reset_n || mode_reg == MODE_RESET) begin
            sw_ctrl_reg <= 4'h0;
            pulse_en_reg <= 1'b0;
            mux_sel_reg <= MUX_SEL_NONE;
            supply_on_reg <= 1'b0;
            cyc_cfg_reg <= 4'h0;
        end else begin
            if (wr_switch) begin
                sw_ctrl_reg <= frame.data;
                pulse_en_reg <= 1'b1;
            end
            if (wr_ok && frame.addr == ADDR_MUX) begin
                mux_sel_reg <= frame.data[2:0];
            end
            // Supply only follows commands given in Normal
            if (wr_ok && frame.addr == ADDR_SUPPLY && mode_reg == MODE_NORMAL) begin
                supply_on_reg <= frame.data[SUPPLY_ON_BIT];
            end
            if (wr_ok && frame.addr == ADDR_CYCLIC) begin
                cyc_cfg_reg <= frame.data;
            end
        end
    end

    // ==========================================================
    // Timers, strap and reset line filter
    logic [PW-1:0] pre_reg;
    logic [15:0] timer_reg;
    logic [1:0] strap_reg;
    logic [15:0] wd_res_reg;
    logic [7:0] rst_flt_reg;
    wire ms_tick = (pre_reg == PRE_LAST);
    wire mode_change = (mode_next != mode_reg);
    wire wd_on = (strap_reg != STRAP_GROUND);
    wire [15:0] wd_limit = (strap_reg == STRAP_OPEN) ? WD_DEFAULT_MS : wd_res_reg;
    // Closed window only applies to the resistor-set period
    wire wd_early = (strap_reg == STRAP_RESISTOR) && (timer_reg < {1'b0, wd_limit[15:1]});
    wire wd_kick = wr_mode && mode_reg == MODE_NORMAL && !wd_early;
    wire wd_fail = wd_on && mode_reg == MODE_NORMAL && ((wr_mode && wd_early) || timer_reg >= wd_limit);
    wire rst_drive = (mode_reg == MODE_RESET) && (timer_reg < RESET_TIME_MS);
    wire rst_in_low = ~rst_s & ~rst_drive;
    wire host_reset = rst_in_low && (rst_flt_reg == RST_FILTER_CYCLES - 8'h01);
    wire timer_clr = mode_change | wd_kick;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pre_reg <= '0;
            timer_reg <= 16'h0000;
            strap_reg <= STRAP_OPEN;
            wd_res_reg <= WD_DEFAULT_MS;
            rst_flt_reg <= 8'h00;
        end else begin
            pre_reg <= (timer_clr || ms_tick) ? '0 : pre_reg + PW'(1);
            if (timer_clr) begin
                timer_reg <= 16'h0000;
            end else if (ms_tick && timer_reg != 16'hFFFF) begin
                timer_reg <= timer_reg + 16'h0001;
            end
            if (mode_reg == MODE_RESET) begin
                strap_reg <= strap_s;
                wd_res_reg <= res_ms_s;
            end
            if (!rst_in_low) begin
                rst_flt_reg <= 8'h00;
            end else if (rst_flt_reg != RST_FILTER_CYCLES) begin
                rst_flt_reg <= rst_flt_reg + 8'h01;
            end
        end
    end

    // ==========================================================
    // Wake detection and cyclic sense
    logic [15:0] cyc_timer_reg;
    logic [7:0] sense_cnt_reg;
    logic sample_reg;
    logic sample_valid_reg;
    wire low_power = is_low_power(mode_reg);
    wire cyc_en = cyc_cfg_reg[CYC_EN_BIT];
    wire [15:0] cyc_period = 16'(CYCLIC_BASE_MS << cyc_cfg_reg[CYC_PER_LSB +: 2]);
    wire cyc_start = low_power && cyc_en && ms_tick && (cyc_timer_reg >= cyc_period - 16'h0001);
    wire sense_on = (sense_cnt_reg != 8'h00);
    wire sense_take = (sense_cnt_reg == 8'h01);
    wire cyc_wake = sense_take && sample_valid_reg && (wake_level != sample_reg);
    wire edge_wake = low_power && !cyc_en && !wake_muxed && (wake_s != wake_d_reg);
    wire wake_any = cyc_wake | edge_wake | (low_power & lin_wake_event);

    always_ff @(posedge sys_clk) begin
        if (!reset_n || !low_power) begin
            cyc_timer_reg <= 16'h0000;
            sense_cnt_reg <= 8'h00;
            sample_reg <= 1'b0;
            sample_valid_reg <= 1'b0;
        end else begin
            if (cyc_start) begin
                cyc_timer_reg <= 16'h0000;
            end else if (ms_tick) begin
                cyc_timer_reg <= cyc_timer_reg + 16'h0001;
            end
            if (cyc_start) begin
                sense_cnt_reg <= SENSE_SETTLE_CYCLES;
            end else if (sense_on) begin
                sense_cnt_reg <= sense_cnt_reg - 8'h01;
            end
            // A muxed wake input reads as low, so no difference ever appears
            if (sense_take) begin
                sample_reg <= wake_level;
                sample_valid_reg <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Mode sequencing
    always_comb begin
        mode_next = mode_reg;
        if (host_reset && mode_reg == MODE_STOP) begin
            mode_next = MODE_NREQ;
        end else if (host_reset) begin
            mode_next = MODE_RESET;
        end else begin
            unique case (mode_reg)
                MODE_RESET: begin
                    if (timer_reg >= RESET_TIME_MS && rst_s) begin
                        mode_next = wd_on ? MODE_NREQ : MODE_NORMAL;
                    end
                end
                MODE_NREQ: begin
                    if (wr_mode && frame.data[1:0] == MODE_CMD_NORMAL) begin
                        mode_next = MODE_NORMAL;
                    end else if (timer_reg >= NREQ_TIMEOUT_MS) begin
                        mode_next = (strap_reg == STRAP_OPEN) ? MODE_NORMAL : MODE_RESET;
                    end
                end
                MODE_NORMAL: begin
                    if (wd_fail) begin
                        mode_next = MODE_RESET;
                    end else if (wr_mode && frame.data[1:0] == MODE_CMD_STOP) begin
                        mode_next = MODE_STOP;
                    end else if (wr_mode && frame.data[1:0] == MODE_CMD_SLEEP) begin
                        mode_next = MODE_SLEEP;
                    end
                end
                MODE_STOP: begin
                    if (wake_any || cs_rise) begin
                        mode_next = MODE_NREQ;
                    end
                end
                MODE_SLEEP: begin
                    if (wake_any) begin
                        mode_next = MODE_RESET;
                    end
                end
                default: begin
                    mode_next = MODE_RESET;
                end
            endcase
        end
    end

    // ==========================================================
    // Interrupt flags and registered outputs
    wire active = is_active(mode_reg);
    wire pulse_ok = active & pulse_en_reg;
    wire sense_one = low_power & sense_on & ~cyc_cfg_reg[CYC_SEL_BIT];
    wire sense_two = low_power & sense_on & cyc_cfg_reg[CYC_SEL_BIT];
    wire gate_one = (pulse_ok & sw_ctrl_reg[SW_ONE_PULSE_BIT]) ? pulse_s : 1'b1;
    wire gate_two = (pulse_ok & sw_ctrl_reg[SW_TWO_PULSE_BIT]) ? pulse_s : 1'b1;
    wire hs_one_next = (active & sw_ctrl_reg[SW_ONE_ON_BIT] & gate_one) | sense_one;
    wire hs_two_next = (active & sw_ctrl_reg[SW_TWO_ON_BIT] & gate_two) | sense_two;
    wire wake_set = (mode_reg == MODE_STOP) && wake_any && !host_reset;
    wire fault_set = active && fault_event;
    wire irq_allowed = (active || mode_reg == MODE_STOP) && rst_s;
    wire irq_next_n = ~((wake_flag_reg | fault_flag_reg) & irq_allowed);

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            mode_reg <= MODE_RESET;
            wake_flag_reg <= 1'b0;
            fault_flag_reg <= 1'b0;
            irq_n <= 1'b1;
            reset_line_oe_n <= 1'b1;
            high_side_switch_one <= 1'b0;
            high_side_switch_two <= 1'b0;
            sensor_supply_output <= 1'b0;
            analog_mux_output <= MUX_SEL_NONE;
        end else begin
            mode_reg <= mode_next;
            // A new event in the read cycle keeps its flag set
            wake_flag_reg <= wake_set | (wake_flag_reg & ~(rd_status & snap_reg[1]));
            fault_flag_reg <= fault_set | (fault_flag_reg & ~(rd_status & snap_reg[0]));
            irq_n <= irq_next_n;
            reset_line_oe_n <= ~rst_drive;
            high_side_switch_one <= hs_one_next;
            high_side_switch_two <= hs_two_next;
            sensor_supply_output <= supply_on_reg & active;
            analog_mux_output <= active ? mux_sel_reg : MUX_SEL_NONE;
        end
    end

    assign device_mode = mode_reg;
    assign reset_line_out = 1'b0;
    assign spi_miso = miso_reg;
    assign spi_miso_oe_n = miso_oe_n_reg;

endmodule

//--- verification/sbchc_core_properties.sv
// Concurrent checks on the ports of the host control interface
module sbchc_core_properties (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic spi_cs_n,
    input wire logic spi_miso_oe_n,
    input wire logic reset_line_in,
    input wire logic reset_line_oe_n,
    input wire logic irq_n,
    input wire logic fault_event,
    input wire logic sensor_supply_output,
    input wire sbchc_pkg::sbchc_mode_t device_mode
);
    timeunit 1ns;
    timeprecision 100ps;
    import sbchc_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // ==========================================================
    // Sequences
    sequence s_stop_cs;
        device_mode == MODE_STOP && irq_n && $rose(spi_cs_n);
    endsequence
    sequence s_back_to_nreq;
        ##[1:6] device_mode == MODE_NREQ;
    endsequence
    // ==========================================================
    // Properties
    property p_miso_hiz;
        spi_cs_n [*4] |-> spi_miso_oe_n;
    endproperty
    property p_cs_wake;
        s_stop_cs |-> s_back_to_nreq;
    endproperty
    // Chip select wake is the host's own doing, so no interrupt follows
    property p_cs_no_irq;
        s_stop_cs |-> irq_n [*6];
    endproperty
    property p_irq_idle;
        (device_mode inside {MODE_RESET, MODE_SLEEP}) [*2] |-> irq_n;
    endproperty
    property p_irq_masked;
        (!reset_line_in) [*4] |-> irq_n;
    endproperty
    property p_drive_in_reset;
        !reset_line_oe_n |-> device_mode == MODE_RESET;
    endproperty
    property p_release_nreq;
        $rose(reset_line_oe_n) |-> ##[1:8] device_mode == MODE_NREQ;
    endproperty
    // A stored enable may reappear on return to Normal Request
    property p_supply_normal;
        $rose(sensor_supply_output) |-> device_mode == MODE_NORMAL || $past(device_mode, 2) != device_mode;
    endproperty
    property p_fault_irq;
        fault_event && reset_line_in && reset_line_oe_n && device_mode == MODE_NORMAL |-> ##[1:3] !irq_n;
    endproperty
    // Only a finished read frame may release the line
    property p_irq_hold;
        (spi_cs_n && !irq_n && device_mode inside {MODE_NREQ, MODE_NORMAL, MODE_STOP}) [*8] |=> !irq_n;
    endproperty
    a_miso_hiz: assert property (p_miso_hiz) else $error("miso enabled with chip select high");
    a_cs_wake: assert property (p_cs_wake) else $error("chip select rise did not wake");
    a_cs_no_irq: assert property (p_cs_no_irq) else $error("interrupt on chip select wake");
    a_irq_idle: assert property (p_irq_idle) else $error("interrupt in reset or sleep");
    a_irq_masked: assert property (p_irq_masked) else $error("interrupt while reset line low");
    a_drive_in_reset: assert property (p_drive_in_reset) else $error("reset line driven outside reset");
    a_release_nreq: assert property (p_release_nreq) else $error("no normal request after release");
    a_supply_normal: assert property (p_supply_normal) else $error("supply switched outside normal");
    a_fault_irq: assert property (p_fault_irq) else $error("fault raised no interrupt");
    a_irq_hold: assert property (p_irq_hold) else $error("interrupt released without read");
endmodule

bind sbchc_core sbchc_core_properties i_props (.sys_clk, .reset_n, .spi_cs_n, .spi_miso_oe_n, .reset_line_in,
    .reset_line_oe_n, .irq_n, .fault_event, .sensor_supply_output, .device_mode);

//--- verification/sbchc_host_model.sv
// Microcontroller model: serial master and its side of the reset wire
module sbchc_host_model (
    input wire logic sys_clk,
    input wire logic spi_miso,
    input wire logic reset_line_oe_n,
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_mosi,
    output logic reset_line_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic host_pull_n = 1'b1;
    logic [7:0] rx_byte = 8'h00;
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // Weak pull-up: the wire is low whenever either side pulls it
    assign reset_line_in = reset_line_oe_n & host_pull_n;
    task automatic half();
        repeat (4) @(posedge sys_clk);
        #1;
    endtask
    // Clock stands low outside frames; a count other than eight is a deliberate fault
    task automatic frame(input logic [7:0] tx, input int nbits);
        spi_cs_n = 1'b0;
        half();
        for (int i = 7; i > 7 - nbits; i--) begin
            spi_mosi = tx[i[2:0]];
            half();
            spi_sclk = 1'b1;
            rx_byte[i[2:0]] = spi_miso;
            half();
            spi_sclk = 1'b0;
        end
        half();
        spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;
        half();
        half();
    endtask
endmodule

//--- verification/sbchc_core_test.sv
// Self-checking bench for the host control interface
module sbchc_core_test;
    timeunit 1ns;
    timeprecision 100ps;
    import sbchc_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic pulse = 1'b0;
    logic wake = 1'b0;
    logic fault_event = 1'b0;
    logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n;
    logic reset_line_in, reset_line_oe_n, irq_n, hs_one, hs_two, supply;
    logic [2:0] mux;
    sbchc_mode_t mode;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    always #5 sys_clk = ~sys_clk;
    sbchc_core #(.CYCLES_PER_MS_P(20)) i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n),
        .reset_line_in(reset_line_in), .reset_line_out(), .reset_line_oe_n(reset_line_oe_n), .irq_n(irq_n),
        .switch_pulse_input(pulse), .watchdog_strap_pin(STRAP_OPEN), .watchdog_resistor_ms(16'h0000),
        .multipurpose_wake_input(wake), .lin_wake_event(1'b0), .fault_event(fault_event),
        .high_side_switch_one(hs_one), .high_side_switch_two(hs_two), .sensor_supply_output(supply),
        .analog_mux_output(mux), .device_mode(mode));
    sbchc_host_model i_host (.sys_clk(sys_clk), .spi_miso(spi_miso), .reset_line_oe_n(reset_line_oe_n),
        .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .reset_line_in(reset_line_in));
    // ==========================================================
    // Shared tasks
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wait_mode(input sbchc_mode_t m, input int limit);
        for (int i = 0; i < limit && mode !== m; i++) step(1);
        check("device_mode", 8'(m), 8'(mode));
    endtask
    task automatic send(input logic [7:0] b);
        i_host.frame(b, 8);
        step(4);
    endtask
    task automatic print_verdict();
        if (fails == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Ceiling well above the longest path, the watchdog wait
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            print_verdict();
        end
    end
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        check("irq_n", 8'h01, 8'(irq_n));
        reset_n = 1'b1;
        step(2);
        check("reset_line_oe_n", 8'h00, 8'(reset_line_oe_n));
        wait_mode(MODE_NREQ, 60);
    endtask
    task automatic t_frames();
        send(8'h80);
        check("device_mode", 8'(MODE_NORMAL), 8'(mode));
        i_host.frame(8'hB1, 7);
        step(4);
        check("short frame supply", 8'h00, 8'(supply));
        send(8'hB1);
        check("sensor_supply_output", 8'h01, 8'(supply));
        i_host.frame(8'h58, 9);
        step(4);
        check("long frame supply", 8'h01, 8'(supply));
    endtask
    task automatic t_pulse();
        send(8'h95);
        check("switch one pulse low", 8'h00, 8'(hs_one));
        pulse = 1'b1;
        step(6);
        check("switch one pulse high", 8'h01, 8'(hs_one));
        send(8'h92);
        check("switches", 8'h02, 8'({hs_two, hs_one}));
    endtask
    task automatic t_irq();
        wake = 1'b1;
        fault_event = 1'b1;
        step(1);
        fault_event = 1'b0;
        step(3);
        check("irq_n set", 8'h00, 8'(irq_n));
        step(40);
        check("irq_n held", 8'h00, 8'(irq_n));
        send(8'h50);
        check("status", {4'hB, 1'b0, MODE_NORMAL}, i_host.rx_byte);
        check("irq_n cleared", 8'h01, 8'(irq_n));
    endtask
    task automatic t_wake();
        send(8'hA2);
        check("analog_mux_output", 8'h02, 8'(mux));
        send(8'h81);
        send(8'h50);
        wait_mode(MODE_NREQ, 10);
        check("irq_n cs wake", 8'h01, 8'(irq_n));
        send(8'h80);
        send(8'h81);
        wake = 1'b0;
        wait_mode(MODE_NREQ, 30);
        step(2);
        check("irq_n input wake", 8'h00, 8'(irq_n));
        send(8'h50);
        send(8'h80);
        send(8'hA1);
        check("analog_mux_output", 8'h01, 8'(mux));
        send(8'h81);
        wake = 1'b1;
        step(30);
        check("muxed input wake", 8'(MODE_STOP), 8'(mode));
        send(8'h50);
        send(8'h80);
        send(8'hA0);
        send(8'hC1);
        send(8'h82);
        step(400);
        wake = 1'b0;
        wait_mode(MODE_RESET, 300);
        wait_mode(MODE_NREQ, 60);
        send(8'h80);
    endtask
    task automatic t_host_reset();
        i_host.host_pull_n = 1'b0;
        step(5);
        i_host.host_pull_n = 1'b1;
        step(10);
        check("glitch", 8'(MODE_NORMAL), 8'(mode));
        i_host.host_pull_n = 1'b0;
        step(20);
        i_host.host_pull_n = 1'b1;
        wait_mode(MODE_RESET, 5);
        wait_mode(MODE_NREQ, 60);
        send(8'h80);
    endtask
    task automatic t_watchdog();
        step(2800);
        check("before timeout", 8'(MODE_NORMAL), 8'(mode));
        wait_mode(MODE_RESET, 500);
    endtask
    initial begin
        step(20);
        t_reset();
        t_frames();
        t_pulse();
        t_irq();
        t_wake();
        t_host_reset();
        t_watchdog();
        print_verdict();
    end
endmodule
